// ---- common/hbdc_defines.svh ----
// Behaviour
// [R01] window code 0-11 gives 6..28 units
// [R02] software never writes window codes 12-15
// [R03] gain codes 0-14 give two to code
// [R04] gain code 15 auto-scales, starting at 64
// [R05] detection runs when enable and channel enable
// [R06] weight codes 0-3 give 2,4,8,16
// [R07] average is (peak + (w-1)*avg) / w
// [R08] threshold is avg*(scale+1)/16
// [R09] bit 14 and bits 7-0 read zero
`ifndef HBDC_DEFINES_SVH
`define HBDC_DEFINES_SVH
`define HBDC_IDX_CONFIG1    6'h1D
`define HBDC_IDX_STATUS     6'h1E
`define HBDC_ADDR_CONFIG1   {`HBDC_IDX_CONFIG1, 2'b00}
`define HBDC_ADDR_STATUS    {`HBDC_IDX_STATUS, 2'b00}
`define HBDC_QRS_WINDOW_WIDTH_RST       4'h3
`define HBDC_GAIN_RST       4'hF
`define HBDC_GAIN_AUTO      4'hF
`define HBDC_GAIN_AUTO_INIT 4'h6
`define HBDC_PEAK_AVG_WEIGHT_RST       2'h2
`define HBDC_PEAK_THRESHOLD_SCALE_RST       4'h3
`define HBDC_QRS_WINDOW_WIDTH_BASE      5'h06
`define HBDC_QRS_WINDOW_WIDTH_MAXCODE   4'hB
`define HBDC_UNIT_MS        8
`define HBDC_UNITS_RST      5'h0C
`define HBDC_MS_RST         8'h60
`define HBDC_GAIN_MAX       4'hE
`define HBDC_RESP_OKAY      2'h0
`define HBDC_RESP_SLVERR    2'h2
`endif

// ---- common/hbdc_pkg.sv ----
package hbdc_pkg;
    typedef enum logic [1:0] {
        HBDC_IDLE,
        HBDC_WRESP,
        HBDC_RRESP
    } hbdc_bus_t;
endpackage

// ---- hw/hbdc_peak_avg.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hbdc_defines.svh"
module hbdc_peak_avg
    import hbdc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        run,
    input  wire logic        peak_valid,
    input  wire logic [15:0] peak_value,
    input  wire logic [1:0]  peak_avg_weight,
    input  wire logic [3:0]  peak_threshold_scale,
    output logic      [15:0] peak_avg,
    output logic      [15:0] threshold
);
    typedef struct packed {
        logic [15:0] avg;
        logic [15:0] thr;
    } hbdc_avg_state_t;

    hbdc_avg_state_t st;
    hbdc_avg_state_t next_st;
    logic [2:0]  shift;
    logic [21:0] acc;
    logic [20:0] prod;

    // recursive average and scaled threshold
    always_comb begin
        next_st = st;
        shift = {1'b0, peak_avg_weight} + 3'h1; // [R06]
        acc = {6'h00, peak_value} + ({6'h00, st.avg} << shift)
            - {6'h00, st.avg};
        prod = {5'h00, st.avg} * ({1'b0, peak_threshold_scale} + 5'h01);
        if (!run) begin
            next_st.avg = 16'h0000;
        end else if (peak_valid) begin
            next_st.avg = 16'(acc >> shift); // [R07]
        end
        next_st.thr = prod[19:4]; // [R08]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign peak_avg  = st.avg;
    assign threshold = st.thr;

    property p_avg_idle;
        @(posedge aclk) disable iff (!aresetn)
        !run |=> peak_avg == 16'h0000;
    endproperty
    a_avg_idle: assert property (p_avg_idle) // [R07]
        else $error("average not cleared when idle");

    property p_thr;
        @(posedge aclk) disable iff (!aresetn)
        ##1 threshold == 16'(({5'h00, $past(peak_avg)}
            * ({1'b0, $past(peak_threshold_scale)} + 5'h01)) >> 4);
    endproperty
    a_thr: assert property (p_thr) // [R08]
        else $error("threshold mismatch");
endmodule
`default_nettype wire

// ---- hw/hbdc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hbdc_defines.svh"
module hbdc_top
    import hbdc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cardiac_channel_enable,
    input  wire logic        peak_valid,
    input  wire logic [15:0] peak_value,
    input  wire logic        gain_up,
    input  wire logic        gain_down,
    output logic             beat_detect_run,
    output logic      [4:0]  window_units,
    output logic      [7:0]  window_ms,
    output logic      [3:0]  gain_shift,
    output logic             gain_auto,
    output logic      [15:0] peak_avg,
    output logic      [15:0] threshold
);
    typedef struct packed {
        hbdc_bus_t   wst;
        hbdc_bus_t   rst;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [3:0]  qrs_window_width;
        logic [3:0]  beat_gain_select;
        logic        beat_detect_enable;
        logic [1:0]  peak_avg_weight;
        logic [3:0]  peak_threshold_scale;
        logic        run;
        logic [4:0]  units;
        logic [7:0]  ms;
        logic [3:0]  gshift;
        logic        gauto;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic        arready;
        logic        rvalid;
    } hbdc_state_t;

    hbdc_state_t st;
    hbdc_state_t next_st;
    logic [23:0] cfg_word;
    logic [15:0] avg_w;
    logic [15:0] thr_w;

    // live register image, unused bits forced to zero
    assign cfg_word = {st.qrs_window_width, st.beat_gain_select,
                       st.beat_detect_enable, 1'b0,
                       st.peak_avg_weight, st.peak_threshold_scale,
                       8'h00}; // [R09]

    hbdc_peak_avg u_avg (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .run                  (st.run),
        .peak_valid           (peak_valid),
        .peak_value           (peak_value),
        .peak_avg_weight      (st.peak_avg_weight),
        .peak_threshold_scale (st.peak_threshold_scale),
        .peak_avg             (avg_w),
        .threshold            (thr_w)
    );

    // bus slave, config decode and gain control
    always_comb begin
        next_st = st;
        // write channel: address and data in either order
        if (st.wst == HBDC_IDLE) begin
            if (s_axi_awvalid && !st.aw_got) begin
                next_st.aw_got = 1'b1;
                next_st.awaddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st.w_got) begin
                next_st.w_got = 1'b1;
                next_st.wdata = s_axi_wdata;
                next_st.wstrb = s_axi_wstrb;
            end
            // both halves held: commit by register index
            if (st.aw_got && st.w_got) begin
                next_st.aw_got = 1'b0;
                next_st.w_got = 1'b0;
                next_st.wst = HBDC_WRESP;
                next_st.bresp = `HBDC_RESP_OKAY;
                if (st.awaddr[7:2] == `HBDC_IDX_CONFIG1) begin
                    if (st.wstrb[2]) begin
                        next_st.qrs_window_width = st.wdata[23:20]; // [R01]
                        next_st.beat_gain_select = st.wdata[19:16];
                    end
                    if (st.wstrb[1]) begin
                        next_st.beat_detect_enable = st.wdata[15];
                        next_st.peak_avg_weight = st.wdata[13:12];
                        next_st.peak_threshold_scale = st.wdata[11:8];
                    end
                    if (st.wstrb[2] && st.wdata[19:16] == `HBDC_GAIN_AUTO)
                        next_st.gshift = `HBDC_GAIN_AUTO_INIT; // [R04]
                end else if (st.awaddr[7:2] == `HBDC_IDX_STATUS) begin
                    next_st.bresp = `HBDC_RESP_SLVERR;
                end else begin
                    next_st.bresp = `HBDC_RESP_SLVERR;
                end
            end
        end else if (s_axi_bready) begin
            next_st.wst = HBDC_IDLE;
        end
        // read channel
        if (st.rst == HBDC_IDLE) begin
            if (s_axi_arvalid) begin
                next_st.rst = HBDC_RRESP;
                next_st.rresp = `HBDC_RESP_OKAY;
                if (s_axi_araddr[7:2] == `HBDC_IDX_CONFIG1) begin
                    next_st.rdata = {8'h00, cfg_word};
                end else if (s_axi_araddr[7:2] == `HBDC_IDX_STATUS) begin
                    next_st.rdata = {7'h00, st.run, st.gauto, 3'h0,
                                     st.gshift, avg_w};
                end else begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = `HBDC_RESP_SLVERR;
                end
            end
        end else if (s_axi_rready) begin
            next_st.rst = HBDC_IDLE;
        end
        // detection gate
        next_st.run = st.beat_detect_enable && cardiac_channel_enable; // [R05]
        // window width in resolution units and milliseconds
        if (st.qrs_window_width <= `HBDC_QRS_WINDOW_WIDTH_MAXCODE) begin
            next_st.units = `HBDC_QRS_WINDOW_WIDTH_BASE
                + {st.qrs_window_width, 1'b0}; // [R01]
        end else begin
            next_st.units = `HBDC_QRS_WINDOW_WIDTH_BASE; // [R02]
        end
        next_st.ms = 8'(next_st.units * `HBDC_UNIT_MS);
        // gain selection: fixed power of two or auto-scale
        next_st.gauto = (st.beat_gain_select == `HBDC_GAIN_AUTO); // [R04]
        if (!next_st.gauto) begin
            next_st.gshift = st.beat_gain_select; // [R03]
        end else if (!st.run || !st.gauto) begin
            // idle, or just switched in from a fixed gain: restart at 64
            next_st.gshift = `HBDC_GAIN_AUTO_INIT; // [R04]
        end else if (gain_up && st.gshift < `HBDC_GAIN_MAX) begin
            next_st.gshift = st.gshift + 4'h1;
        end else if (gain_down && st.gshift != 4'h0) begin
            next_st.gshift = st.gshift - 4'h1;
        end
        // handshake flags registered for the next cycle
        next_st.awready = (next_st.wst == HBDC_IDLE) && !next_st.aw_got;
        next_st.wready  = (next_st.wst == HBDC_IDLE) && !next_st.w_got;
        next_st.bvalid  = (next_st.wst == HBDC_WRESP);
        next_st.arready = (next_st.rst == HBDC_IDLE);
        next_st.rvalid  = (next_st.rst == HBDC_RRESP);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.qrs_window_width <= `HBDC_QRS_WINDOW_WIDTH_RST;
            st.beat_gain_select <= `HBDC_GAIN_RST;
            st.peak_avg_weight <= `HBDC_PEAK_AVG_WEIGHT_RST; // [R06]
            st.peak_threshold_scale <= `HBDC_PEAK_THRESHOLD_SCALE_RST;
            st.beat_detect_enable <= 1'b0; // [R05]
            st.units <= `HBDC_UNITS_RST;
            st.ms <= `HBDC_MS_RST;
            st.gshift <= `HBDC_GAIN_AUTO_INIT;
            st.gauto <= 1'b1;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready   = st.awready;
    assign s_axi_wready    = st.wready;
    assign s_axi_bvalid    = st.bvalid;
    assign s_axi_bresp     = st.bresp;
    assign s_axi_arready   = st.arready;
    assign s_axi_rvalid    = st.rvalid;
    assign s_axi_rdata     = st.rdata;
    assign s_axi_rresp     = st.rresp;
    assign beat_detect_run = st.run;
    assign window_units    = st.units;
    assign window_ms       = st.ms;
    assign gain_shift      = st.gshift;
    assign gain_auto       = st.gauto;
    assign peak_avg        = avg_w;
    assign threshold       = thr_w;

    property p_run;
        @(posedge aclk) disable iff (!aresetn)
        ##1 beat_detect_run == ($past(st.beat_detect_enable)
                                && $past(cardiac_channel_enable));
    endproperty
    a_run: assert property (p_run) // [R05]
        else $error("run not enable and channel enable");

    property p_win;
        @(posedge aclk) disable iff (!aresetn)
        st.qrs_window_width <= 4'hB |=>
            window_units == 5'h06 + {$past(st.qrs_window_width), 1'b0};
    endproperty
    a_win: assert property (p_win) // [R01]
        else $error("window units wrong");

    property p_gain_fixed;
        @(posedge aclk) disable iff (!aresetn)
        st.beat_gain_select != 4'hF |=> gain_shift == $past(st.beat_gain_select)
            && !gain_auto;
    endproperty
    a_gain_fixed: assert property (p_gain_fixed) // [R03]
        else $error("fixed gain wrong");

    property p_gain_auto;
        @(posedge aclk) disable iff (!aresetn)
        st.beat_gain_select == 4'hF && !st.run |=> gain_shift == 4'h6;
    endproperty
    a_gain_auto: assert property (p_gain_auto) // [R04]
        else $error("auto gain not starting at 64");

    property p_zero_bits;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr[7:2] == `HBDC_IDX_CONFIG1
            |=> s_axi_rdata[31:24] == 8'h00 && s_axi_rdata[14] == 1'b0
            && s_axi_rdata[7:0] == 8'h00;
    endproperty
    a_zero_bits: assert property (p_zero_bits) // [R09]
        else $error("unused bits read nonzero");

    property p_wait_b;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_wait_b: assert property (p_wait_b)
        else $error("bvalid dropped early");

    property p_aw_busy;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_busy: assert property (p_aw_busy)
        else $error("write taken while response pending");

    property p_ar_busy;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy)
        else $error("read taken while response pending");

    property p_rd_unmapped;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr[7:2] != `HBDC_IDX_CONFIG1
            && s_axi_araddr[7:2] != `HBDC_IDX_STATUS
            |=> s_axi_rresp == `HBDC_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");

    property p_win_ms;
        @(posedge aclk) disable iff (!aresetn)
        window_ms == {window_units, 3'h0};
    endproperty
    a_win_ms: assert property (p_win_ms) // [R01]
        else $error("window ms not eight per unit");

    property p_gain_range;
        @(posedge aclk) disable iff (!aresetn)
        gain_shift != 4'hF;
    endproperty
    a_gain_range: assert property (p_gain_range) // [R03]
        else $error("gain shift out of range");

    property p_auto_entry;
        @(posedge aclk) disable iff (!aresetn)
        $rose(gain_auto) |-> gain_shift == `HBDC_GAIN_AUTO_INIT;
    endproperty
    a_auto_entry: assert property (p_auto_entry) // [R04]
        else $error("auto gain not entered at 64");
endmodule
`default_nettype wire

// ---- sim/hbdc_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hbdc_defines.svh"
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t %s", $time, m); end end
module hbdc_top_tb
    import hbdc_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, peak_valid;
    logic        cardiac_channel_enable, gain_up, gain_down;
    logic        beat_detect_run, gain_auto;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, window_ms;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, gain_shift;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] peak_value, peak_avg, threshold;
    logic [4:0]  window_units;
    int          n_fail, checks, m;
    logic [15:0] pk [3] = '{16'hFFFF, 16'h1234, 16'h0007};

    hbdc_top hbdc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cardiac_channel_enable,
        .peak_valid, .peak_value, .gain_up, .gain_down, .beat_detect_run,
        .window_units, .window_ms, .gain_shift, .gain_auto, .peak_avg,
        .threshold);

    // clock at 4 ns period
    always #2 aclk = ~aclk;

    // config word from its fields
    function automatic logic [31:0] cfg(input logic [3:0] w, input logic [3:0] g,
        input logic en, input logic [1:0] pa, input logic [3:0] ps);
        return {8'h00, w, g, en, 1'b0, pa, ps, 8'h00};
    endfunction

    // bus write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w || b) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (b && s_axi_bvalid) begin
                b = 1'b0;
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    // bus read: rready held until the answer is sampled
    task automatic axr(input logic [7:0] a);
        logic ar, r;
        ar = 1'b1;
        r = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (ar || r) begin
            @(posedge aclk);
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (r && s_axi_rvalid) begin
                r = 1'b0;
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    // let a few edges pass, then look at settled outputs
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // one-cycle pulse on a gain step or a peak
    task automatic pulse(input int kind, input logic [15:0] v);
        @(posedge aclk);
        gain_up <= (kind == 1);
        gain_down <= (kind == 2);
        peak_valid <= (kind == 0);
        peak_value <= v;
        @(posedge aclk);
        gain_up <= 1'b0;
        gain_down <= 1'b0;
        peak_valid <= 1'b0;
        settle();
    endtask

    task automatic t_reset();
        axr(`HBDC_ADDR_CONFIG1);
        `CHK(rd, 32'h003F2300, "config reset word")
        `CHK({window_units, window_ms}, {5'h0C, 8'h60}, "reset window")
        `CHK({gain_auto, gain_shift}, 5'h16, "reset gain")
        `CHK(beat_detect_run, 1'b0, "reset run")
        axr(`HBDC_ADDR_STATUS);
        `CHK(rd, 32'h00860000, "status reset")
        $display("t_reset done");
    endtask

    task automatic t_codes();
        for (int c = 0; c < 15; c++) begin
            m = (c > 11) ? 11 : c;
            axw(`HBDC_ADDR_CONFIG1, cfg(m[3:0], c[3:0], 1'b0, 2'h2, 4'h3));
            settle();
            `CHK(window_units, 5'(6 + 2 * m), "window units")
            `CHK(window_ms, 8'((6 + 2 * m) * 8), "window ms")
            `CHK({gain_auto, gain_shift}, {1'b0, c[3:0]}, "gain")
        end
        $display("t_codes done");
    endtask

    task automatic t_bus();
        axw(`HBDC_ADDR_CONFIG1, 32'hFFBFFFFF);
        `CHK(rsp, `HBDC_RESP_OKAY, "config write resp")
        axr(`HBDC_ADDR_CONFIG1);
        `CHK(rd, 32'h00BFBF00, "unused bits")
        @(posedge aclk);
        s_axi_wstrb <= 4'h4;
        axw(`HBDC_ADDR_CONFIG1, 32'h0);
        s_axi_wstrb <= 4'hF;
        axr(`HBDC_ADDR_CONFIG1);
        `CHK(rd, 32'h0000BF00, "upper byte strobe only")
        axw(`HBDC_ADDR_STATUS, 32'h0);
        `CHK(rsp, `HBDC_RESP_SLVERR, "status write resp")
        axr(8'h10);
        `CHK({rsp, rd}, {`HBDC_RESP_SLVERR, 32'h0}, "unmapped read")
        $display("t_bus done");
    endtask

    task automatic t_enable();
        axw(`HBDC_ADDR_CONFIG1, cfg(4'h3, 4'hF, 1'b1, 2'h2, 4'h3));
        settle();
        `CHK(beat_detect_run, 1'b0, "run without channel")
        @(posedge aclk);
        cardiac_channel_enable <= 1'b1;
        settle();
        `CHK(beat_detect_run, 1'b1, "run with both")
        axw(`HBDC_ADDR_CONFIG1, cfg(4'h3, 4'hF, 1'b0, 2'h2, 4'h3));
        settle();
        `CHK(beat_detect_run, 1'b0, "run after disable")
        $display("t_enable done");
    endtask

    task automatic t_peak();
        for (int k = 0; k < 4; k++) begin
            axw(`HBDC_ADDR_CONFIG1, cfg(4'h3, 4'h0, 1'b1, k[1:0], 4'(k * 5)));
            m = 0;
            for (int j = 0; j < 3; j++) begin
                pulse(0, pk[j]);
                m = (pk[j] + ((2 << k) - 1) * m) / (2 << k);
                `CHK(peak_avg, 16'(m), "peak average")
                `CHK(threshold, 16'((m * (k * 5 + 1)) >> 4), "thr")
            end
            axw(`HBDC_ADDR_CONFIG1, cfg(4'h3, 4'h0, 1'b0, 2'h2, 4'h3));
        end
        $display("t_peak done");
    endtask

    task automatic t_auto();
        axw(`HBDC_ADDR_CONFIG1, cfg(4'h3, 4'h2, 1'b1, 2'h2, 4'h3));
        settle();
        `CHK(gain_shift, 4'h2, "fixed gain while running")
        axw(`HBDC_ADDR_CONFIG1, cfg(4'h3, 4'hF, 1'b1, 2'h2, 4'h3));
        pulse(1, 16'h0);
        `CHK({gain_auto, gain_shift}, 5'h17, "auto step up")
        pulse(2, 16'h0);
        pulse(2, 16'h0);
        `CHK(gain_shift, 4'h5, "auto step down")
        axw(`HBDC_ADDR_CONFIG1, cfg(4'h3, 4'hF, 1'b1, 2'h2, 4'h3));
        settle();
        `CHK(gain_shift, 4'h6, "auto restart at 64")
        $display("t_auto done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #40000; // about thirty-five times the scenarios' length
        n_fail++;
        results();
    end

    // reset, then the scenarios in turn
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, peak_valid, gain_up, gain_down} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, peak_value} = '0;
        s_axi_wstrb = 4'hF;
        cardiac_channel_enable = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        t_reset();
        t_codes();
        t_bus();
        t_enable();
        t_peak();
        t_auto();
        results();
    end
endmodule
`default_nettype wire
